// ### inc/tcp_regs.svh
`ifndef TCP_REGS_SVH
`define TCP_REGS_SVH
// ----------------------------------------
// field positions of the control words
// ----------------------------------------
`define TCP_RUN_BIT        0
`define TCP_PRUN_BIT       2
`define TCP_UDCE_BIT       4
`define TCP_DBUF_BIT       7
`define TCP_MODE_CLK_LSB   0
`define TCP_MODE_CAP_LSB   2
`define TCP_MODE_CLR_BIT   4
`define TCP_FFC_INIT_LSB   0
`define TCP_FFC_TMA_BIT    2
`define TCP_FFC_TMB_BIT    3
`define TCP_FFC_TCA_BIT    4
// ----------------------------------------
// codes and reset values
// ----------------------------------------
`define TCP_FF_CLEAR_CODE  2'h3
`define TCP_FF_SET_CODE    2'h2
`define TCP_UD_MIDSCALE    16'h7FFF
`define TCP_CNT_ZERO       16'h0000
`define TCP_CNT_ONES       16'hFFFF
`define TCP_PRE_DIV        8'h04
`endif

// ### inc/tcp_pkg.sv
package tcp_pkg;
  // capture trigger select encodings
  typedef enum logic [1:0] {
    TCP_CAP_OFF  = 2'h0,
    TCP_CAP_A    = 2'h1,
    TCP_CAP_AB   = 2'h2,
    TCP_CAP_GATE = 2'h3
  } tcp_cap_sel_t;
  // captured pair
  typedef struct packed {
    logic [15:0] cap_a;
    logic [15:0] cap_b;
  } tcp_capture_t;
  // two-phase status flags
  typedef struct packed {
    logic count;
    logic under;
    logic over;
  } tcp_ud_status_t;
endpackage : tcp_pkg

// ### verilog/tcp_sync.sv
`timescale 1ns/10ps
`include "tcp_regs.svh"
// three-stage synchroniser with agreement of the last two stages
module tcp_sync
  import tcp_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic din,
  output logic      dout
);
  logic [2:0] sh_r;  // shift chain
  // ----------------------------------------
  // chain
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sh_r <= 3'h0;
    end else begin
      sh_r <= {sh_r[1:0], din};
    end
  end
  // output changes only when stages two and three agree
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      dout <= 1'b0;
    end else if (sh_r[1] == sh_r[2]) begin
      dout <= sh_r[2];
    end
  end
endmodule : tcp_sync

// ### verilog/tcp_presc.sv
`timescale 1ns/10ps
`include "tcp_regs.svh"
// prescaler: one tick every div cycles while running
module tcp_presc
  import tcp_pkg::*;
#(
  parameter logic [7:0] DIV = `TCP_PRE_DIV
)(
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic run,
  output logic      tick
);
  logic [7:0] cnt_r;  // divide counter
  // ----------------------------------------
  // divider
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst || !run) begin
      cnt_r <= 8'h00;
      tick  <= 1'b0;
    end else if (cnt_r == DIV - 8'h01) begin
      cnt_r <= 8'h00;
      tick  <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 8'h01;
      tick  <= 1'b0;
    end
  end
endmodule : tcp_presc

// ### verilog/tcp_timer.sv
`timescale 1ns/10ps
`include "tcp_regs.svh"
module tcp_timer
  import tcp_pkg::*;
#(
  parameter logic [7:0] PRE_DIV = `TCP_PRE_DIV
)(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic [7:0]  run_control,
  input  wire logic [7:0]  mode_config,
  input  wire logic [7:0]  flop_control,
  input  wire logic        flop_control_wr,
  input  wire logic [15:0] compare_a_data,
  input  wire logic        compare_a_wr,
  input  wire logic [15:0] compare_b_data,
  input  wire logic        compare_b_wr,
  input  wire logic        status_rd,
  input  wire logic        external_count_in,
  input  wire logic        capture_in_a,
  input  wire logic        capture_in_b,
  input  wire logic        gate_flop,
  output logic [15:0]      up_counter,
  output logic [15:0]      compare_reg_a,
  output logic [15:0]      compare_reg_b,
  output tcp_capture_t     captures,
  output tcp_ud_status_t   updown_status,
  output logic             pulse_out_pin,
  output logic             match_irq,
  output logic             ext_irq_a,
  output logic             ext_irq_b
);
  // ----------------------------------------
  // control field decode
  // ----------------------------------------
  logic         run_en;       // counter run
  logic         pre_run;      // prescaler run
  logic         ud_en;        // two-phase mode
  logic         dbuf_en;      // compare A double buffer
  logic         ext_clk_sel;  // clock source is the pin
  tcp_cap_sel_t cap_sel;      // capture trigger select
  logic         clr_on_b;     // counter clear on match B
  logic         tog_a_en_r;   // toggle on match A
  logic         tog_b_en_r;   // toggle on match B
  logic         tog_cap_en_r; // toggle on capture A
  assign run_en      = run_control[`TCP_RUN_BIT];
  assign pre_run     = run_control[`TCP_PRUN_BIT];
  assign ud_en       = run_control[`TCP_UDCE_BIT];
  assign dbuf_en     = run_control[`TCP_DBUF_BIT];
  // clock field: 00 is the pin, any other code the one prescaler tick
  assign ext_clk_sel =
    (mode_config[`TCP_MODE_CLK_LSB +: 2] == 2'h0);
  assign cap_sel     =
    tcp_cap_sel_t'(mode_config[`TCP_MODE_CAP_LSB +: 2]);
  assign clr_on_b    = mode_config[`TCP_MODE_CLR_BIT];

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  logic cin_s, ina_s, inb_s, gate_s;  // synchronised pins
  tcp_sync u_sync_cin (.ref_clk(ref_clk), .rst(rst),
                       .din(external_count_in), .dout(cin_s));
  tcp_sync u_sync_ina (.ref_clk(ref_clk), .rst(rst),
                       .din(capture_in_a), .dout(ina_s));
  tcp_sync u_sync_inb (.ref_clk(ref_clk), .rst(rst),
                       .din(capture_in_b), .dout(inb_s));
  tcp_sync u_sync_gate (.ref_clk(ref_clk), .rst(rst),
                        .din(gate_flop), .dout(gate_s));

  // previous values for edge detection, taken after the sync
  logic cin_d_r, ina_d_r, inb_d_r, gate_d_r;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cin_d_r  <= 1'b0;
      ina_d_r  <= 1'b0;
      inb_d_r  <= 1'b0;
      gate_d_r <= 1'b0;
    end else begin
      cin_d_r  <= cin_s;
      ina_d_r  <= ina_s;
      inb_d_r  <= inb_s;
      gate_d_r <= gate_s;
    end
  end

  logic cin_rise, ina_rise, ina_fall, inb_rise, gate_rise, gate_fall;
  assign cin_rise  = cin_s & ~cin_d_r;
  assign ina_rise  = ina_s & ~ina_d_r;
  assign ina_fall  = ~ina_s & ina_d_r;
  assign inb_rise  = inb_s & ~inb_d_r;
  assign gate_rise = gate_s & ~gate_d_r;
  assign gate_fall = ~gate_s & gate_d_r;

  // ----------------------------------------
  // prescaler and count tick
  // ----------------------------------------
  logic pre_tick;  // prescaler output
  tcp_presc #(.DIV(PRE_DIV)) u_presc (
    .ref_clk (ref_clk),
    .rst     (rst),
    .run     (pre_run),
    .tick    (pre_tick)
  );
  logic cnt_tick;  // one count step
  assign cnt_tick = ext_clk_sel ? cin_rise : pre_tick;

  // ----------------------------------------
  // match detection
  // ----------------------------------------
  // the comparator is idle in two-phase mode
  logic match_a, match_b;
  assign match_a = run_en && !ud_en && cnt_tick &&
                   (up_counter == compare_reg_a);
  assign match_b = run_en && !ud_en && cnt_tick &&
                   (up_counter == compare_reg_b);

  // ----------------------------------------
  // two-phase decode
  // ----------------------------------------
  // gray step: up when a leads b, down when b leads a
  function automatic logic [1:0] tcp_quad_step(
    input logic [1:0] prev,
    input logic [1:0] cur
  );
    logic [1:0] r;
    r = 2'h0;
    case ({prev, cur})
      4'h1, 4'h7, 4'hE, 4'h8: r = 2'h1;  // up
      4'h2, 4'hB, 4'hD, 4'h4: r = 2'h2;  // down
      default:                r = 2'h0;
    endcase
    return r;
  endfunction : tcp_quad_step

  logic [1:0] qstep;  // 01 up, 10 down
  assign qstep = tcp_quad_step({inb_d_r, ina_d_r}, {inb_s, ina_s});
  logic ud_up, ud_dn;
  assign ud_up = ud_en && run_en && qstep == 2'h1;
  assign ud_dn = ud_en && run_en && qstep == 2'h2;

  // ----------------------------------------
  // up counter
  // ----------------------------------------
  logic ud_en_d_r;  // detects entry into two-phase mode
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ud_en_d_r <= 1'b0;
    end else begin
      ud_en_d_r <= ud_en;
    end
  end

  logic [15:0] cnt_nxt;
  always_comb begin
    cnt_nxt = up_counter;
    if (!run_en) begin
      cnt_nxt = `TCP_CNT_ZERO;
    end else if (ud_en && !ud_en_d_r) begin
      cnt_nxt = `TCP_UD_MIDSCALE;
    end else if (ud_up) begin
      cnt_nxt = up_counter + 16'h0001;  // wraps to zero
    end else if (ud_dn) begin
      cnt_nxt = up_counter - 16'h0001;  // wraps to ones
    end else if (match_b && clr_on_b) begin
      cnt_nxt = `TCP_CNT_ZERO;
    end else if (!ud_en && cnt_tick) begin
      cnt_nxt = up_counter + 16'h0001;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      up_counter <= `TCP_CNT_ZERO;
    end else begin
      up_counter <= cnt_nxt;
    end
  end

  // ----------------------------------------
  // compare registers and buffer
  // ----------------------------------------
  logic [15:0] cmp_a_buf_r;  // pending compare A value
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cmp_a_buf_r <= `TCP_CNT_ZERO;
    end else if (compare_a_wr) begin
      cmp_a_buf_r <= compare_a_data;
    end
  end
  // buffered writes wait for match B so a period is never split
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      compare_reg_a <= `TCP_CNT_ZERO;
    end else if (compare_a_wr && !dbuf_en) begin
      compare_reg_a <= compare_a_data;
    end else if (dbuf_en && match_b) begin
      compare_reg_a <= cmp_a_buf_r;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      compare_reg_b <= `TCP_CNT_ZERO;
    end else if (compare_b_wr) begin
      compare_reg_b <= compare_b_data;
    end
  end

  // ----------------------------------------
  // capture logic
  // ----------------------------------------
  logic armed_b_r;  // rising A seen, waiting for fall
  logic cap_a_ev, cap_b_ev;
  always_comb begin
    cap_a_ev = 1'b0;
    cap_b_ev = 1'b0;
    if (!ud_en) begin
      case (cap_sel)
        TCP_CAP_A: begin
          cap_a_ev = ina_rise;
          cap_b_ev = ina_fall && armed_b_r;
        end
        TCP_CAP_AB: begin
          cap_a_ev = ina_rise;
          cap_b_ev = inb_rise;
        end
        TCP_CAP_GATE: begin
          cap_a_ev = gate_rise;
          cap_b_ev = gate_fall && armed_b_r;
        end
        default: begin
          cap_a_ev = 1'b0;  // capture disabled
          cap_b_ev = 1'b0;
        end
      endcase
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      armed_b_r <= 1'b0;
    end else if (cap_a_ev) begin
      armed_b_r <= 1'b1;
    end else if (cap_b_ev) begin
      armed_b_r <= 1'b0;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      captures <= '0;
    end else begin
      if (cap_a_ev) begin
        captures.cap_a <= up_counter;
      end
      if (cap_b_ev) begin
        captures.cap_b <= up_counter;
      end
    end
  end

  // ----------------------------------------
  // toggle flop
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tog_a_en_r   <= 1'b0;
      tog_b_en_r   <= 1'b0;
      tog_cap_en_r <= 1'b0;
    end else if (flop_control_wr) begin
      tog_a_en_r   <= flop_control[`TCP_FFC_TMA_BIT];
      tog_b_en_r   <= flop_control[`TCP_FFC_TMB_BIT];
      tog_cap_en_r <= flop_control[`TCP_FFC_TCA_BIT];
    end
  end
  logic tog_ev;  // odd number of enabled toggle causes in the cycle
  assign tog_ev = (match_a && tog_a_en_r) ^ (match_b && tog_b_en_r)
                  ^ (cap_a_ev && tog_cap_en_r);
  // a preload write wins; it is used before counting starts
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pulse_out_pin <= 1'b0;
    end else if (flop_control_wr &&
                 flop_control[`TCP_FFC_INIT_LSB +: 2] ==
                 `TCP_FF_CLEAR_CODE) begin
      pulse_out_pin <= 1'b0;
    end else if (flop_control_wr &&
                 flop_control[`TCP_FFC_INIT_LSB +: 2] ==
                 `TCP_FF_SET_CODE) begin
      pulse_out_pin <= 1'b1;
    end else if (tog_ev) begin
      pulse_out_pin <= ~pulse_out_pin;
    end
  end

  // ----------------------------------------
  // interrupts and two-phase status
  // ----------------------------------------
  logic ovf, unf;
  assign ovf = ud_up && up_counter == `TCP_CNT_ONES;
  assign unf = ud_dn && up_counter == `TCP_CNT_ZERO;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      match_irq <= 1'b0;
      ext_irq_a <= 1'b0;
      ext_irq_b <= 1'b0;
    end else begin
      match_irq <= match_b || ud_up || ud_dn;
      ext_irq_a <= (!ud_en && ina_rise) ||
                   (!ud_en && cap_sel == TCP_CAP_A && ina_fall);
      ext_irq_b <= !ud_en && inb_rise;
    end
  end
  // a new event in the read cycle survives the clear
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      updown_status <= '0;
    end else begin
      updown_status.count <= (ud_up || ud_dn) ||
                             (updown_status.count && !status_rd);
      updown_status.over  <= ovf ||
                             (updown_status.over && !status_rd);
      updown_status.under <= unf ||
                             (updown_status.under && !status_rd);
    end
  end
endmodule : tcp_timer

// ### testbench/tcp_assertions.sv
`timescale 1ns/10ps
// checker on the timer ports, one clock domain
module tcp_assertions
  import tcp_pkg::*;
#(
  parameter logic [7:0] PRE_DIV = 8'h04
)(
  input wire logic           ref_clk,
  input wire logic           rst,
  input wire logic [7:0]     run_control,
  input wire logic [7:0]     mode_config,
  input wire logic [15:0]    compare_a_data,
  input wire logic           compare_a_wr,
  input wire logic [15:0]    compare_b_data,
  input wire logic           compare_b_wr,
  input wire logic           status_rd,
  input wire logic [15:0]    up_counter,
  input wire logic [15:0]    compare_reg_a,
  input wire logic [15:0]    compare_reg_b,
  input wire tcp_ud_status_t updown_status,
  input wire logic           match_irq
);
  // ----------------------------------------
  // sequences
  // ----------------------------------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // settled two-phase mode, entry load has had time to land
  sequence s_ud_on;
    run_control[4] && run_control[0] &&
    $past(run_control[4], 3) && $past(run_control[0], 3);
  endsequence
  // period end with clear option in normal mode
  sequence s_clr_hit;
    match_irq && mode_config[4] && !run_control[4];
  endsequence
  // ----------------------------------------
  // properties
  // ----------------------------------------
  stop_clear_a: assert property (
    !run_control[0] |=> up_counter == 16'h0000)
    else $error("counter not held at zero while stopped");
  cmp_b_load_a: assert property (
    compare_b_wr |=> compare_reg_b == $past(compare_b_data))
    else $error("compare b write lost");
  direct_a_a: assert property (
    compare_a_wr && !run_control[7] |=>
      compare_reg_a == $past(compare_a_data))
    else $error("unbuffered compare a write lost");
  dbuf_hold_a: assert property (
    compare_a_wr && run_control[7] |=> compare_reg_a ==
      $past(compare_reg_a) || match_irq || $past(match_irq))
    else $error("buffered compare a changed before match b");
  clr_period_a: assert property (
    s_clr_hit |-> ##[0:1] up_counter == 16'h0000)
    else $error("counter not cleared at match b");
  ud_step_a: assert property (
    s_ud_on ##0 $changed(up_counter) |->
      up_counter - $past(up_counter) inside {16'h0001, 16'hFFFF})
    else $error("two-phase counter moved by more than one");
  ud_irq_a: assert property (
    s_ud_on ##0 $changed(up_counter) |-> ##[0:1] match_irq)
    else $error("two-phase step without interrupt");
  status_clr_a: assert property (
    status_rd && !run_control[4] |=> updown_status == 3'h0)
    else $error("status flags survive a read");
  irq_pulse_a: assert property (
    match_irq && !run_control[4] |=> !match_irq)
    else $error("match interrupt longer than one cycle");
endmodule : tcp_assertions

bind tcp_timer tcp_assertions #(.PRE_DIV(PRE_DIV)) u_chk (
  .ref_clk, .rst, .run_control, .mode_config, .compare_a_data,
  .compare_a_wr, .compare_b_data, .compare_b_wr, .status_rd,
  .up_counter, .compare_reg_a, .compare_reg_b, .updown_status,
  .match_irq
);

// ### testbench/tcp_pins.sv
`timescale 1ns/10ps
// far side: trigger, gate, count and quadrature sources
module tcp_pins (
  input  wire logic ref_clk,
  output logic      capture_in_a,
  output logic      capture_in_b,
  output logic      external_count_in,
  output logic      gate_flop
);
  // ----------------------------------------
  // pin drivers
  // ----------------------------------------
  // all sources idle low until a scenario asks
  initial begin
    {gate_flop, external_count_in, capture_in_b, capture_in_a} = 4'h0;
  end
  // drive {gate, count, b, a} after an edge and hold n cycles
  task drv(input logic [3:0] v, input int n);
    @(posedge ref_clk);
    {gate_flop, external_count_in, capture_in_b, capture_in_a} <= v;
    repeat (n - 1) @(posedge ref_clk);
  endtask : drv
  // one full gray cycle, one line moves per step, held long
  // enough for the input synchronisers to see every state
  task quad(input logic up);
    logic [7:0] s;
    s = up ? 8'h2D : 8'h1E;
    for (int i = 0; i < 4; i++) begin
      drv({2'h0, s[2*i +: 2]}, 8);
    end
  endtask : quad
endmodule : tcp_pins

// ### testbench/tb.sv
`timescale 1ns/10ps
module tb;
  import tcp_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  localparam logic [7:0] DIV = 8'h02; // short prescale, brief runs
  logic           ref_clk, rst, flop_control_wr, compare_a_wr;
  logic           compare_b_wr, status_rd, pulse_out_pin;
  logic           match_irq, ext_irq_a, ext_irq_b;
  logic           capture_in_a, capture_in_b, external_count_in;
  logic           gate_flop;
  logic [7:0]     run_control, mode_config, flop_control;
  logic [15:0]    compare_a_data, compare_b_data, up_counter;
  logic [15:0]    compare_reg_a, compare_reg_b, ca;
  tcp_capture_t   captures;
  tcp_ud_status_t updown_status;
  int             fails, checks, seed, ni, nia, nib, n0, a, b, h;

  tcp_timer #(.PRE_DIV(DIV)) u_dut (.*);
  tcp_pins u_pins (.ref_clk, .capture_in_a, .capture_in_b,
    .external_count_in, .gate_flop);

  always #5 ref_clk = ~ref_clk;
  // interrupt pulse tallies, read as differences
  always @(negedge ref_clk) begin
    if (match_irq === 1'b1) ni++;
    if (ext_irq_a === 1'b1) nia++;
    if (ext_irq_b === 1'b1) nib++;
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task chk(input string what, input logic [15:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task stop_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : stop_test
  task set(input logic [7:0] r, m);
    @(posedge ref_clk);
    run_control <= r;
    mode_config <= m;
  endtask : set
  // one-cycle write: 0 compare a, 1 compare b, 2 flop control
  task wr(input int sel, input logic [15:0] v);
    @(posedge ref_clk);
    compare_a_data <= v;
    compare_b_data <= v;
    if (sel == 2) flop_control <= v[7:0];
    compare_a_wr    <= (sel == 0);
    compare_b_wr    <= (sel == 1);
    flop_control_wr <= (sel == 2);
    @(posedge ref_clk);
    {compare_a_wr, compare_b_wr, flop_control_wr} <= 3'h0;
  endtask : wr
  task wait_irq;
    int k;
    k = 0;
    do begin
      @(negedge ref_clk);
      k++;
    end while (match_irq !== 1'b1 && k < 300);
    chk("irq seen", k < 300, 1);
  endtask : wait_irq
  // pulse train model: two toggles and one irq per period
  task pulse_pattern_mode(input logic [7:0] ffc, input logic init);
    int tg, t0, nirq, per;
    int q[$];  // expected toggle times, in cycles from the start
    logic last;
    a = 2 + {$random(seed)} % 6;
    b = a + 2 + {$random(seed)} % 6;
    set(8'h00, 8'h11);
    wr(0, 16'(a));
    wr(1, 16'(b));
    wr(2, {8'h00, ffc});
    set(8'h05, 8'h11);
    @(negedge ref_clk);
    chk("flop preload", pulse_out_pin, init);
    per = (b + 1) * DIV;
    // counter steps every DIV cycles from zero, cleared after match b
    q.delete();
    for (int k = 0; k < 3; k++) begin
      q.push_back((a + 1) * DIV + k * per); // toggle at match a
      q.push_back(per + k * per);           // toggle at match b
    end
    last = init;
    tg = 0;
    t0 = 0;
    nirq = 0;
    for (int i = 0; i < 3 * per + 6; i++) begin
      @(negedge ref_clk);
      if (pulse_out_pin !== last) begin
        if (tg == 0) chk("first edge", pulse_out_pin, !init);
        chk("toggle time", i, (q.size() > 0) ? q.pop_front() : -1);
        tg++;
        last = pulse_out_pin;
      end
      if (match_irq === 1'b1) begin
        if (nirq > 0) chk("period", i - t0, per);
        nirq++;
        t0 = i;
      end
    end
    chk("toggles", tg, 2 * nirq);
    chk("irqs", nirq, 3);
  endtask : pulse_pattern_mode
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    ref_clk = 0;
    rst = 1;
    seed = 32'hE5E1;
    {run_control, mode_config, flop_control} = 24'h0;
    {compare_a_data, compare_b_data} = 32'h0;
    {flop_control_wr, compare_a_wr, compare_b_wr, status_rd} = 4'h0;
    {fails, checks, ni, nia, nib} = '0;
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    @(negedge ref_clk);
    chk("reset counter", up_counter, 16'h0000);
    pulse_pattern_mode(8'h0F, 1'b0);
    pulse_pattern_mode(8'h0E, 1'b1);
    // duty change lands only at match b
    wait_irq;
    set(8'h85, 8'h11);
    wr(0, 16'(a - 1));
    @(negedge ref_clk);
    chk("held in buffer", compare_reg_a, a);
    wait_irq;
    repeat (2) @(negedge ref_clk);
    chk("reloaded", compare_reg_a, a - 1);
    set(8'h05, 8'h11);
    wr(0, 16'(a));
    @(negedge ref_clk);
    chk("direct write", compare_reg_a, a);
    // single-input width, capture a also toggles the flop
    wr(2, 16'h0013);
    set(8'h05, 8'h05);
    h = DIV * (3 + {$random(seed)} % 8);
    n0 = nia;
    u_pins.drv(4'h1, h);
    u_pins.drv(4'h0, 20);
    @(negedge ref_clk);
    chk("width", captures.cap_b - captures.cap_a, h / DIV);
    chk("irq a count", nia - n0, 2);
    chk("one-shot", pulse_out_pin, 1);
    // delayed one-shot: compares placed after the captured count
    ca = captures.cap_a + 16'h0040;
    wr(0, ca);
    wr(1, ca + 16'h0010);
    wr(2, 16'h000F); // clear flop, toggle on both matches
    n0 = 0;
    repeat (200) begin
      @(negedge ref_clk);
      n0 += pulse_out_pin;
    end
    chk("delayed width", n0, 16'h0010 * DIV);
    wr(2, 16'h0000);
    // two-input time difference
    set(8'h05, 8'h09);
    h = DIV * (2 + {$random(seed)} % 8);
    n0 = nib;
    u_pins.drv(4'h1, h);
    u_pins.drv(4'h3, 10);
    u_pins.drv(4'h0, 20);
    @(negedge ref_clk);
    chk("difference", captures.cap_b - captures.cap_a, h / DIV);
    chk("irq b count", nib - n0, 1);
    // gated event count on the external clock
    set(8'h05, 8'h0C);
    h = 2 + {$random(seed)} % 6;
    u_pins.drv(4'h8, 10);
    repeat (h) begin
      u_pins.drv(4'hC, 4);
      u_pins.drv(4'h8, 4);
    end
    u_pins.drv(4'h8, 8);
    u_pins.drv(4'h0, 20);
    @(negedge ref_clk);
    chk("gate count", captures.cap_b - captures.cap_a, h);
    // capture disabled keeps registers
    set(8'h05, 8'h01);
    ca = captures.cap_a;
    u_pins.drv(4'h1, 8);
    u_pins.drv(4'h0, 20);
    @(negedge ref_clk);
    chk("capture off", captures.cap_a, ca);
    set(8'h00, 8'h11);
    repeat (2) @(negedge ref_clk);
    chk("stopped", up_counter, 16'h0000);
    // two-phase count: out one cycle and back again
    set(8'h11, 8'h00);
    repeat (4) @(negedge ref_clk);
    chk("midscale", up_counter, 16'h7FFF);
    n0 = ni;
    u_pins.quad(1'b1);
    repeat (6) @(negedge ref_clk);
    chk("moved", up_counter, 16'h8003);
    u_pins.quad(1'b0);
    repeat (6) @(negedge ref_clk);
    chk("back", up_counter, 16'h7FFF);
    chk("step irqs", ni - n0, 8);
    chk("count flag", updown_status.count, 1);
    set(8'h00, 8'h00);
    @(posedge ref_clk);
    status_rd <= 1'b1;
    @(posedge ref_clk);
    status_rd <= 1'b0;
    @(negedge ref_clk);
    chk("status cleared", updown_status, 3'h0);
    stop_test;
  end
  // hang guard, well past the expected run length
  initial begin
    #300000;
    fails++;
    stop_test;
  end
endmodule : tb
